// file: core/icache_diag_pkg.sv
// Constants shared by the instruction cache diagnostic register block.
// Assumes one core clock and the internal processor register strobe port.
//
// What this block does
// - With the cache disabled, register reads and writes index the arrays by the index register.
// - A parity error captures the faulting address tag bits into index bits 31:11.
// - Index row field selects the array row and is loaded from the address on error.
// - Index subblock field selects the quadword; errors load it with address bits 4:3.
// - Write-only longword select picks low or high longword for data register accesses.
// - Tag register bits 31:11 move to or from the tag array entry.
// - Tag register bit 8 moves tag parity to or from the tag array.
// - Tag register holds four parity and four valid bits, one pair per subblock.
// - Data write with select clear holds data in the fill buffer low half only.
// - Data write with select set fills the high half and writes the quadword.
// - Data read with select clear reads the subblock and returns its low longword.
// - Data read with select set returns the high longword of the earlier read.
// - A tag array parity error sets the tag parity error flag.
// - A data array parity error sets the data parity error flag.
// - Either error flag setting also sets the write-to-clear lock bit.
// - While locked, error flags and captured tag bits stay frozen until software clears it; index register writes still load the row and subblock fields.
// - Cache access enable resets to zero; the cache is used only while it is set.
`default_nettype none

package icache_diag_pkg;
  // ****************************************************************
  // Register offsets on the internal processor register port.
  // ****************************************************************
  localparam int OFS_W = 8;
  localparam logic [OFS_W-1:0] IDX_OFS = 8'hd0;
  localparam logic [OFS_W-1:0] TAG_OFS = 8'hd1;
  localparam logic [OFS_W-1:0] DATA_OFS = 8'hd2;
  localparam logic [OFS_W-1:0] CSR_OFS = 8'hd3;

  // ****************************************************************
  // Field layouts.
  // ****************************************************************
  localparam int WORD_W = 32;
  localparam int QW_W = 64;
  localparam int TAG_MSB = 31;
  localparam int TAG_LSB = 11;
  localparam int TAG_W = TAG_MSB - TAG_LSB + 1;
  localparam int ROW_MSB = 10;
  localparam int ROW_LSB = 5;
  localparam int ROW_W = ROW_MSB - ROW_LSB + 1;
  localparam int SUB_MSB = 4;
  localparam int SUB_LSB = 3;
  localparam int SUB_W = SUB_MSB - SUB_LSB + 1;
  localparam int NSUB = 4;
  localparam int LW_BIT = 2;
  localparam int TPAR_BIT = 8;
  localparam int DPAR_LSB = 4;
  localparam int DVAL_LSB = 0;
  localparam int TPERR_BIT = 4;
  localparam int DPERR_BIT = 3;
  localparam int LOCK_BIT = 2;
  localparam int ENB_BIT = 0;
endpackage

`default_nettype wire

// file: core/icache_array_if.sv
// Carries array address, write data and registered read data.
// Assumes the controller drives the request side and the store answers.
`default_nettype none

interface icache_array_if;
  import icache_diag_pkg::*;
  logic [ROW_W-1:0] row;
  logic [SUB_W-1:0] sub;
  logic tag_we;
  logic [TAG_W-1:0] tag_wd;
  logic tpar_wd;
  logic [NSUB-1:0] dpar_wd;
  logic [NSUB-1:0] dval_wd;
  logic data_we;
  logic [QW_W-1:0] data_wd;
  logic [TAG_W-1:0] q_tag;
  logic q_tpar;
  logic [NSUB-1:0] q_dpar;
  logic [NSUB-1:0] q_dval;
  logic [QW_W-1:0] q_data;
  logic q_dpar_sel;
  logic q_dval_sel;

  modport ctrl (output row, sub, tag_we, tag_wd, tpar_wd, dpar_wd, dval_wd, data_we, data_wd,
    input q_tag, q_tpar, q_dpar, q_dval, q_data, q_dpar_sel, q_dval_sel);
  modport store (input row, sub, tag_we, tag_wd, tpar_wd, dpar_wd, dval_wd, data_we, data_wd,
    output q_tag, q_tpar, q_dpar, q_dval, q_data, q_dpar_sel, q_dval_sel);
endinterface

`default_nettype wire

// file: core/icache_store.sv
// Tag and data arrays of the instruction cache, flip-flop storage.
// Assumes one write per cycle per array; read data appears one edge after the address.
`default_nettype none

module icache_store #(
  parameter int ROWS = 64
) (
  input wire logic clk,
  input wire logic rstn,
  icache_array_if.store arr
);
  import icache_diag_pkg::*;

  logic [TAG_W-1:0] tag_mem [ROWS];
  logic tpar_mem [ROWS];
  logic [NSUB-1:0] dpar_mem [ROWS];
  logic [NSUB-1:0] dval_mem [ROWS];
  logic [QW_W-1:0] data_mem [ROWS][NSUB];

  // ****************************************************************
  // Writes.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (arr.tag_we) begin
      tag_mem[arr.row] <= arr.tag_wd;
      tpar_mem[arr.row] <= arr.tpar_wd;
      dpar_mem[arr.row] <= arr.dpar_wd;
      dval_mem[arr.row] <= arr.dval_wd;
    end
    if (arr.data_we) begin
      data_mem[arr.row][arr.sub] <= arr.data_wd;
    end
  end

  // ****************************************************************
  // Registered read of the addressed row and subblock.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arr.q_tag <= '0;
      arr.q_tpar <= 1'b0;
      arr.q_dpar <= '0;
      arr.q_dval <= '0;
      arr.q_data <= '0;
      arr.q_dpar_sel <= 1'b0;
      arr.q_dval_sel <= 1'b0;
    end else begin
      arr.q_tag <= tag_mem[arr.row];
      arr.q_tpar <= tpar_mem[arr.row];
      arr.q_dpar <= dpar_mem[arr.row];
      arr.q_dval <= dval_mem[arr.row];
      arr.q_data <= data_mem[arr.row][arr.sub];
      arr.q_dpar_sel <= dpar_mem[arr.row][arr.sub];
      arr.q_dval_sel <= dval_mem[arr.row][arr.sub];
    end
  end
endmodule // icache_store

`default_nettype wire

// file: core/icache_diag.sv
// Diagnostic register access to the instruction cache arrays and parity error capture.
// Assumes a one-cycle read or write strobe on the internal processor register port
// and a fetch unit that issues one lookup per strobe.
`default_nettype none

module icache_diag #(
  parameter int ROWS = 64
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [icache_diag_pkg::OFS_W-1:0] ipr_addr,
  input wire logic ipr_wr,
  input wire logic ipr_rd,
  input wire logic [icache_diag_pkg::WORD_W-1:0] ipr_wdata,
  output logic [icache_diag_pkg::WORD_W-1:0] ipr_rdata,
  output logic ipr_rvalid,
  input wire logic fetch_rd,
  input wire logic [icache_diag_pkg::WORD_W-1:0] fetch_vaddr,
  output logic fetch_done,
  output logic fetch_hit,
  output logic [icache_diag_pkg::QW_W-1:0] fetch_data,
  output logic cache_access_enable
);
  import icache_diag_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [TAG_W-1:0] err_tag_reg;
  logic [ROW_W-1:0] row_reg;
  logic [SUB_W-1:0] sub_reg;
  logic longword_select_reg;
  logic tperr_reg;
  logic dperr_reg;
  logic lock_reg;
  logic enable_reg;
  logic [WORD_W-1:0] fill_lo_reg;
  logic [WORD_W-1:0] hold_hi_reg;
  logic rd_pend_reg;
  logic [OFS_W-1:0] rd_ofs_reg;
  logic rd_lw_reg;
  logic rd_diag_reg;
  logic fpend_reg;
  logic [WORD_W-1:0] fv_reg;

  logic wr_idx;
  logic wr_tag;
  logic wr_data;
  logic wr_csr;
  logic diag_ok;
  logic fetch_take;
  logic lock_clr;
  logic t_err;
  logic d_err;
  logic capture;
  logic [WORD_W-1:0] rd_word;

  icache_array_if arr ();

  icache_store #(
    .ROWS(ROWS)
  ) store_inst (
    .clk(clk),
    .rstn(rstn),
    .arr(arr)
  );

  // ****************************************************************
  // Register port decode.
  // ****************************************************************
  assign diag_ok = !enable_reg;
  assign wr_idx = ipr_wr && (ipr_addr == IDX_OFS);
  assign wr_tag = ipr_wr && (ipr_addr == TAG_OFS) && diag_ok;
  assign wr_data = ipr_wr && (ipr_addr == DATA_OFS) && diag_ok;
  assign wr_csr = ipr_wr && (ipr_addr == CSR_OFS);
  assign lock_clr = wr_csr && ipr_wdata[LOCK_BIT];
  assign fetch_take = fetch_rd && enable_reg;
  assign cache_access_enable = enable_reg;

  // ****************************************************************
  // Array request: fetch lookups while enabled, the index register otherwise.
  // ****************************************************************
  always_comb begin
    if (enable_reg) begin
      arr.row = fetch_vaddr[ROW_MSB:ROW_LSB];
      arr.sub = fetch_vaddr[SUB_MSB:SUB_LSB];
    end else begin
      arr.row = row_reg;
      arr.sub = sub_reg;
    end
  end

  assign arr.tag_we = wr_tag;
  assign arr.tag_wd = ipr_wdata[TAG_MSB:TAG_LSB];
  assign arr.tpar_wd = ipr_wdata[TPAR_BIT];
  assign arr.dpar_wd = ipr_wdata[DPAR_LSB +: NSUB];
  assign arr.dval_wd = ipr_wdata[DVAL_LSB +: NSUB];
  assign arr.data_we = wr_data && longword_select_reg;
  assign arr.data_wd = {ipr_wdata, fill_lo_reg};

  // ****************************************************************
  // Parity check of the looked-up entry and error capture gate.
  // ****************************************************************
  assign t_err = fpend_reg && (arr.q_tpar != ^arr.q_tag);
  assign d_err = fpend_reg && arr.q_dval_sel && (arr.q_dpar_sel != ^arr.q_data);
  // A lock cleared in the same cycle no longer blocks a new error.
  assign capture = (t_err || d_err) && !(lock_reg && !lock_clr);

  // ****************************************************************
  // Index register: error address capture wins over a software write.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_tag_reg <= '0;
      row_reg <= '0;
      sub_reg <= '0;
    end else if (capture) begin
      err_tag_reg <= fv_reg[TAG_MSB:TAG_LSB];
      row_reg <= fv_reg[ROW_MSB:ROW_LSB];
      sub_reg <= fv_reg[SUB_MSB:SUB_LSB];
    end else if (wr_idx) begin
      row_reg <= ipr_wdata[ROW_MSB:ROW_LSB];
      sub_reg <= ipr_wdata[SUB_MSB:SUB_LSB];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      longword_select_reg <= 1'b0;
    end else if (wr_idx) begin
      longword_select_reg <= ipr_wdata[LW_BIT];
    end
  end

  // ****************************************************************
  // Control and status: error flags, lock and access enable.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tperr_reg <= 1'b0;
      dperr_reg <= 1'b0;
    end else if (capture) begin
      tperr_reg <= t_err;
      dperr_reg <= d_err;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_reg <= 1'b0;
    end else if (capture) begin
      lock_reg <= 1'b1;
    end else if (lock_clr) begin
      lock_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= 1'b0;
    end else if (wr_csr) begin
      enable_reg <= ipr_wdata[ENB_BIT];
    end
  end

  // ****************************************************************
  // Fill buffer low half, loaded only by a low-longword data write.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fill_lo_reg <= '0;
    end else if (wr_data && !longword_select_reg) begin
      fill_lo_reg <= ipr_wdata;
    end
  end

  // ****************************************************************
  // Register reads: taken at the strobe, answered two edges later.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pend_reg <= 1'b0;
      rd_ofs_reg <= '0;
      rd_lw_reg <= 1'b0;
      rd_diag_reg <= 1'b0;
    end else begin
      rd_pend_reg <= ipr_rd;
      if (ipr_rd) begin
        rd_ofs_reg <= ipr_addr;
        rd_lw_reg <= longword_select_reg;
        rd_diag_reg <= diag_ok;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (rd_ofs_reg)
      IDX_OFS: begin
        rd_word[TAG_MSB:TAG_LSB] = err_tag_reg;
        rd_word[ROW_MSB:ROW_LSB] = row_reg;
        rd_word[SUB_MSB:SUB_LSB] = sub_reg;
      end
      TAG_OFS: begin
        if (rd_diag_reg) begin
          rd_word[TAG_MSB:TAG_LSB] = arr.q_tag;
          rd_word[TPAR_BIT] = arr.q_tpar;
          rd_word[DPAR_LSB +: NSUB] = arr.q_dpar;
          rd_word[DVAL_LSB +: NSUB] = arr.q_dval;
        end
      end
      DATA_OFS: begin
        if (rd_diag_reg) begin
          rd_word = rd_lw_reg ? hold_hi_reg : arr.q_data[WORD_W-1:0];
        end
      end
      CSR_OFS: begin
        rd_word[TPERR_BIT] = tperr_reg;
        rd_word[DPERR_BIT] = dperr_reg;
        rd_word[LOCK_BIT] = lock_reg;
        rd_word[ENB_BIT] = enable_reg;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ipr_rdata <= '0;
      ipr_rvalid <= 1'b0;
    end else begin
      ipr_rvalid <= rd_pend_reg;
      if (rd_pend_reg) begin
        ipr_rdata <= rd_word;
      end
    end
  end

  // The high longword is kept from the low read; no second array access follows.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_hi_reg <= '0;
    end else if (rd_pend_reg && rd_diag_reg && rd_ofs_reg == DATA_OFS && !rd_lw_reg) begin
      hold_hi_reg <= arr.q_data[QW_W-1:WORD_W];
    end
  end

  // ****************************************************************
  // Fetch lookup: parity check one edge after the request, hit and data two edges after it.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fpend_reg <= 1'b0;
      fv_reg <= '0;
    end else begin
      fpend_reg <= fetch_take;
      if (fetch_take) begin
        fv_reg <= fetch_vaddr;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_done <= 1'b0;
      fetch_hit <= 1'b0;
      fetch_data <= '0;
    end else begin
      fetch_done <= fpend_reg;
      fetch_hit <= fpend_reg && arr.q_dval_sel && !t_err && !d_err
        && (arr.q_tag == fv_reg[TAG_MSB:TAG_LSB]);
      if (fpend_reg) begin
        fetch_data <= arr.q_data;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  diag_index_a: assert property (!enable_reg |-> (arr.row == row_reg && arr.sub == sub_reg))
    else $error("diagnostic access not indexed by index register");
  err_addr_a: assert property (capture |=> err_tag_reg == $past(fv_reg[TAG_MSB:TAG_LSB]))
    else $error("error tag not captured");
  err_row_sub_a: assert property (capture |=> (row_reg == $past(fv_reg[ROW_MSB:ROW_LSB])
      && sub_reg == $past(fv_reg[SUB_MSB:SUB_LSB])))
    else $error("error row or subblock not captured");
  lw_select_a: assert property (wr_idx |=> longword_select_reg == $past(ipr_wdata[LW_BIT]))
    else $error("longword select not written");
  tag_write_a: assert property (wr_tag |-> (arr.tag_we && arr.tag_wd == ipr_wdata[TAG_MSB:TAG_LSB]
      && arr.tpar_wd == ipr_wdata[TPAR_BIT] && arr.dval_wd == ipr_wdata[NSUB-1:0]))
    else $error("tag write fields wrong");
  low_hold_a: assert property ((wr_data && !longword_select_reg) |-> !arr.data_we
      ##1 fill_lo_reg == $past(ipr_wdata))
    else $error("low data write misbehaved");
  fill_write_a: assert property ((wr_data && longword_select_reg) |-> (arr.data_we
      && arr.data_wd == {ipr_wdata, fill_lo_reg}))
    else $error("quadword fill write wrong");
  low_read_a: assert property ((ipr_rd && ipr_addr == DATA_OFS && !enable_reg
      && !longword_select_reg) |-> ##2 (ipr_rvalid
      && ipr_rdata == $past(arr.q_data[WORD_W-1:0])))
    else $error("low longword read wrong");
  high_read_a: assert property ((ipr_rd && ipr_addr == DATA_OFS && !enable_reg
      && longword_select_reg) |-> ##2 (ipr_rvalid
      && ipr_rdata == $past(hold_hi_reg)))
    else $error("high longword read wrong");
  error_flags_a: assert property (capture |=> (tperr_reg == $past(t_err)
      && dperr_reg == $past(d_err) && lock_reg))
    else $error("error flags or lock not set");
  lock_freeze_a: assert property ((lock_reg && !lock_clr) |=> ($stable(err_tag_reg)
      && $stable(tperr_reg) && $stable(dperr_reg) && lock_reg))
    else $error("locked error record changed");
  enable_gate_a: assert property (fetch_done |-> $past(enable_reg, 2))
    else $error("lookup without access enable");
  fill_keep_a: assert property (!(wr_data && !longword_select_reg) |=> $stable(fill_lo_reg))
    else $error("fill buffer low half disturbed");

  capture_c: cover property (capture);
  fill_write_c: cover property (wr_data && !longword_select_reg ##[1:8] arr.data_we);
  high_read_c: cover property (ipr_rd && ipr_addr == DATA_OFS && longword_select_reg);
  lock_clear_c: cover property (lock_reg && lock_clr);
endmodule // icache_diag

`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the instruction cache diagnostic register block.
// Assumes core/icache_diag.sv and its package; the bench drives every port itself.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import icache_diag_pkg::*;

  logic clk;
  logic rstn;
  logic ipr_wr;
  logic ipr_rd;
  logic fetch_rd;
  logic [OFS_W-1:0] ipr_addr;
  logic [WORD_W-1:0] ipr_wdata;
  logic [WORD_W-1:0] ipr_rdata;
  logic [WORD_W-1:0] fetch_vaddr;
  logic ipr_rvalid;
  logic fetch_done;
  logic fetch_hit;
  logic cache_access_enable;
  logic [QW_W-1:0] fetch_data;
  int errors;
  int n_compared;
  int seed_dummy;
  logic [WORD_W-1:0] rq[$];
  logic [QW_W+1:0] fq[$];
  logic [QW_W+1:0] f;
  logic [TAG_W-1:0] t1;
  logic [TAG_W-1:0] t2;
  logic [QW_W-1:0] d1;
  logic [QW_W-1:0] d2;
  logic [WORD_W-1:0] va;

  icache_diag dut_u (.clk(clk), .rstn(rstn), .ipr_addr(ipr_addr), .ipr_wr(ipr_wr),
    .ipr_rd(ipr_rd), .ipr_wdata(ipr_wdata), .ipr_rdata(ipr_rdata), .ipr_rvalid(ipr_rvalid),
    .fetch_rd(fetch_rd), .fetch_vaddr(fetch_vaddr), .fetch_done(fetch_done),
    .fetch_hit(fetch_hit), .fetch_data(fetch_data),
    .cache_access_enable(cache_access_enable));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic check(input logic [QW_W-1:0] got, input logic [QW_W-1:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [WORD_W-1:0] ix(input logic [ROW_W-1:0] r,
                                           input logic [SUB_W-1:0] s, input logic lw);
    return {{TAG_W{1'b0}}, r, s, lw, 2'b00};
  endfunction

  task automatic wr(input logic [OFS_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk);
    ipr_addr <= a;
    ipr_wdata <= d;
    ipr_wr <= 1'b1;
    @(posedge clk);
    ipr_wr <= 1'b0;
  endtask

  // The expected answer is noted before the strobe; the monitor takes it off in order.
  task automatic rd(input logic [OFS_W-1:0] a, input logic [WORD_W-1:0] e);
    @(posedge clk);
    ipr_addr <= a;
    ipr_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    ipr_rd <= 1'b0;
  endtask

  task automatic fetch(input logic [WORD_W-1:0] v, input logic take, input logic h,
                       input logic chk, input logic [QW_W-1:0] e);
    @(posedge clk);
    fetch_vaddr <= v;
    fetch_rd <= 1'b1;
    if (take) begin
      fq.push_back({h, chk, e});
    end
    @(posedge clk);
    fetch_rd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wq(input logic [ROW_W-1:0] r, input logic [SUB_W-1:0] s,
                    input logic [QW_W-1:0] q);
    wr(IDX_OFS, ix(r, s, 1'b0));
    wr(DATA_OFS, q[31:0]);
    wr(IDX_OFS, ix(r, s, 1'b1));
    wr(DATA_OFS, q[63:32]);
  endtask

  task automatic cq(input logic [ROW_W-1:0] r, input logic [SUB_W-1:0] s,
                    input logic [QW_W-1:0] q);
    wr(IDX_OFS, ix(r, s, 1'b0));
    rd(DATA_OFS, q[31:0]);
    wr(IDX_OFS, ix(r, s, 1'b1));
    rd(DATA_OFS, q[63:32]);
  endtask

  // ****************************************************************
  // Output monitor.
  // ****************************************************************
  always @(posedge clk) begin
    if (ipr_rvalid === 1'b1) begin
      if (rq.size() == 0) begin
        check(64'h1, 64'h0, "unexpected read answer");
      end else begin
        check({32'h0, ipr_rdata}, {32'h0, rq.pop_front()}, "read data");
      end
    end
    if (fetch_done === 1'b1) begin
      if (fq.size() == 0) begin
        check(64'h1, 64'h0, "unexpected lookup answer");
      end else begin
        f = fq.pop_front();
        check({63'h0, fetch_hit}, {63'h0, f[QW_W+1]}, "lookup hit");
        if (f[QW_W]) begin
          check(fetch_data, f[QW_W-1:0], "lookup data");
        end
      end
    end
  end

  initial begin
    #(50 * 5000);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    ipr_addr = '0;
    ipr_wr = 1'b0;
    ipr_rd = 1'b0;
    ipr_wdata = '0;
    fetch_rd = 1'b0;
    fetch_vaddr = '0;
    seed_dummy = $urandom(32'hab217276);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(CSR_OFS, 32'h0);
    rd(IDX_OFS, 32'h0);
    rd(8'hd4, 32'h0);
    wr(IDX_OFS, 32'hffff_ffff);
    rd(IDX_OFS, 32'h0000_07f8);
    for (int i = 0; i < 8; i++) begin
      va = $urandom;
      d1 = {$urandom, $urandom};
      wr(IDX_OFS, ix(va[10:5], va[4:3], 1'b0));
      wr(TAG_OFS, va & 32'hffff_f9ff);
      rd(TAG_OFS, va & 32'hffff_f9ff);
      wq(va[10:5], va[4:3], d1);
      cq(va[10:5], va[4:3], d1);
    end
    va = $urandom;
    t1 = va[TAG_MSB:TAG_LSB];
    va = $urandom;
    t2 = va[TAG_MSB:TAG_LSB];
    d1 = {$urandom, $urandom};
    d2 = {$urandom, $urandom};
    wq(6'd5, 2'd2, d1);
    wq(6'd5, 2'd1, d2);
    wr(IDX_OFS, ix(6'd5, 2'd0, 1'b0));
    wr(TAG_OFS, {t1, 2'b00, ^t1, 1'b0, ^d1, ~^d2, 1'b0, 4'b0110});
    wr(IDX_OFS, ix(6'd9, 2'd0, 1'b0));
    wr(TAG_OFS, {t2, 2'b00, ~^t2, 4'h0, 4'h1});
    fetch({t1, 6'd5, 2'd2, 3'h0}, 1'b0, 1'b0, 1'b0, 64'h0);
    @(negedge clk);
    check({63'h0, cache_access_enable}, 64'h0, "enable output");
    wr(CSR_OFS, 32'h1);
    @(negedge clk);
    check({63'h0, cache_access_enable}, 64'h1, "enable output");
    rd(CSR_OFS, 32'h1);
    rd(TAG_OFS, 32'h0);
    fetch({t1, 6'd5, 2'd2, 3'h0}, 1'b1, 1'b1, 1'b1, d1);
    fetch({t1 ^ 21'h1, 6'd5, 2'd2, 3'h0}, 1'b1, 1'b0, 1'b0, 64'h0);
    rd(CSR_OFS, 32'h1);
    va = {t2, 6'd9, 2'd3, 3'h5};
    fetch(va, 1'b1, 1'b0, 1'b0, 64'h0);
    rd(CSR_OFS, 32'h15);
    rd(IDX_OFS, {va[31:3], 3'h0});
    fetch({t1, 6'd5, 2'd1, 3'h0}, 1'b1, 1'b0, 1'b0, 64'h0);
    rd(CSR_OFS, 32'h15);
    rd(IDX_OFS, {va[31:3], 3'h0});
    wr(CSR_OFS, 32'h5);
    fetch({t1, 6'd5, 2'd1, 3'h0}, 1'b1, 1'b0, 1'b0, 64'h0);
    rd(CSR_OFS, 32'h0d);
    rd(IDX_OFS, {t1, 6'd5, 2'd1, 3'h0});
    wr(CSR_OFS, 32'h4);
    rd(CSR_OFS, 32'h08);
    repeat (5) @(posedge clk);
    check({rq.size(), fq.size()}, 64'h0, "answers missing");
    finish_test();
  end
endmodule // tb

`default_nettype wire
